// ==== logic/clmd_map.vh ====
// constants for the core logic and move datapath
// assumes inclusion by bare name from the design files under logic/
`ifndef CLMD_MAP_VH
`define CLMD_MAP_VH

// instruction word fields
`define CLMD_IW_W         12
`define CLMD_OP4_HI       11
`define CLMD_OP4_LO       8
`define CLMD_OP6_LO       6
`define CLMD_DEST_BIT     5
`define CLMD_FADDR_HI     4
`define CLMD_K_HI         7

// literal opcode prefixes (upper four bits)
`define CLMD_OP_LOAD_LIT  4'hc
`define CLMD_OP_OR_LIT    4'hd
`define CLMD_OP_XOR_LIT   4'hf

// register opcode prefixes (upper six bits)
`define CLMD_OP_OR_REG    6'h04
`define CLMD_OP_XOR_REG   6'h06
`define CLMD_OP_MOVE_REG  6'h08

// configuration and direction loads
`define CLMD_OP_CONFIG    12'h002
`define CLMD_OP_DIR_HI    9'h000
`define CLMD_DIR_SEL_A    3'h5
`define CLMD_DIR_SEL_B    3'h6
`define CLMD_DIR_SEL_C    3'h7

// logic unit operations
`define CLMD_LU_OR        2'h0
`define CLMD_LU_XOR       2'h1
`define CLMD_LU_PASS      2'h2

// file addresses
`define CLMD_FA_INDIRECT  5'h00
`define CLMD_FA_TIMER     5'h01
`define CLMD_FA_PCL       5'h02
`define CLMD_FA_FLAGS     5'h03
`define CLMD_FA_POINTER   5'h04
`define CLMD_FA_PINS_A    5'h05
`define CLMD_FA_PINS_B    5'h06
`define CLMD_FA_PINS_C    5'h07
`define CLMD_FILE_DEPTH   32

// flag register layout
`define CLMD_FL_PAGE_HI   7
`define CLMD_FL_PAGE_LO   5
`define CLMD_FL_EXPIRY    4
`define CLMD_FL_PWRDN     3
`define CLMD_FL_ZERO      2
`define CLMD_FL_LOW_HI    2

// widths
`define CLMD_PC_W         11
`define CLMD_CFG_W        6
`define CLMD_PA_W         4
`define CLMD_CFG_CLK_SRC  5

// reset values
`define CLMD_RST_FLAGS    8'h18
`define CLMD_RST_PC       11'h7ff
`define CLMD_RST_CFG      6'h3f
`define CLMD_RST_DIR8     8'hff
`define CLMD_RST_DIR4     4'hf
`define CLMD_RST_PTR_TOP  3'h7
`define CLMD_RST_PTR_BIT7 1'h1
`define CLMD_ZERO8        8'h00
`define CLMD_ZERO4        4'h0
`define CLMD_ONE8         8'h01
`define CLMD_ONE_PC       11'h001

`endif

// ==== logic/clmd_logic_unit.v ====
// combinational logic unit: or, exclusive-or and pass of the file or literal operand
// assumes the caller registers the result and the zero indication
`timescale 1ns/100ps
`default_nettype none
`include "clmd_map.vh"

module clmd_logic_unit (
    input  wire [1:0] op,
    input  wire [7:0] acc,
    input  wire [7:0] operand,
    output reg  [7:0] result,
    output wire       zero
);

    // operation select; pass serves both moves and literal loads
    always @* begin
        case (op)
            `CLMD_LU_OR:   result = acc | operand;
            `CLMD_LU_XOR:  result = acc ^ operand;
            `CLMD_LU_PASS: result = operand;
            default:       result = operand;
        endcase
    end

    // zero flag source: set only for an all-zero result
    assign zero = (result == `CLMD_ZERO8);

endmodule // clmd_logic_unit
`default_nettype wire

// ==== logic/clmd_core.v ====
// core datapath: accumulator, file registers and logic/move instructions
// assumes one instruction word per accepted strobe, pins synchronous to clk_sys
// and a reset held at least one edge; the caller keeps por steady while rst is high
`timescale 1ns/100ps
`default_nettype none
`include "clmd_map.vh"

// Summary of operation
// - or_literal_op (prefix 1101) ors the accumulator with the immediate, keeps it there and sets zero flag.
// - or_register_op (0001 00df ffff) ors accumulator with file f, result to accumulator or f by d, zero flag set.
// - move_file_op (0010 00df ffff) copies file f into accumulator or back into f and sets zero from it.
// - move_file_op with d set leaves the register as it was but still updates the zero flag.
// - xor_literal_op (prefix 1111) xors the accumulator with the immediate and updates the zero flag.
// - xor_register_op (0001 10df ffff) xors accumulator with file f, result by d, zero flag updated.
// - file address 00h is no register but reaches the location addressed by pointer_reg at 04h.
// - file address 02h shows only the low program counter byte and upper bits are never file-visible.
// - a build parameter turns file address 07h into a plain general purpose register instead of pins_group_c.
// - on small-memory builds pointer_reg resets its top three bits to one and keeps its low five on a warm reset.
// - unimplemented register bits read as zero, such as the upper nibble of pins_group_a.
// - power-on reset sets every direction_regs bit to one so all pins start as inputs.
// - timer_prescale_config is six bits wide and resets to all ones.
module clmd_core #(
    parameter SMALL_MEM = 1
) (
    input  wire                     clk_sys,
    input  wire                     rst,
    input  wire                     ce,
    input  wire                     por,
    input  wire                     instr_valid,
    input  wire [`CLMD_IW_W-1:0]    instr_word,
    input  wire [`CLMD_PA_W-1:0]    pins_group_a_in,
    input  wire [7:0]               pins_group_b_in,
    input  wire [7:0]               pins_group_c_in,
    output reg  [7:0]               acc_q,
    output reg  [7:0]               core_flags_q,
    output reg  [7:0]               pointer_reg_q,
    output reg  [7:0]               timer_count_q,
    output reg  [`CLMD_PC_W-1:0]    pc_q,
    output reg  [`CLMD_CFG_W-1:0]   timer_prescale_config_q,
    output reg  [`CLMD_PA_W-1:0]    pins_group_a_q,
    output reg  [7:0]               pins_group_b_q,
    output reg  [7:0]               pins_group_c_q,
    output reg  [`CLMD_PA_W-1:0]    direction_a_q,
    output reg  [7:0]               direction_b_q,
    output reg  [7:0]               direction_c_q
);

    ////////////////////////////////////////////////////////////////////////////
    // storage

    // general purpose file; low entries shadowed by special registers
    reg  [7:0] file_mem [0:`CLMD_FILE_DEPTH-1];

    ////////////////////////////////////////////////////////////////////////////
    // decode

    // decoded strobes, all gated by go so a frozen core decodes nothing
    wire [3:0] op4;
    wire [5:0] op6;
    wire       dest_file;
    wire [4:0] faddr;
    wire [7:0] imm;
    wire       do_load_lit;
    wire       do_or_lit;
    wire       do_xor_lit;
    wire       do_or_reg;
    wire       do_xor_reg;
    wire       do_move_reg;
    wire       do_config;
    wire       do_dir;
    wire       is_lit;
    wire       is_reg;
    wire       go;

    // instruction fields, each word one cycle
    assign go          = ce & instr_valid;
    assign op4         = instr_word[`CLMD_OP4_HI:`CLMD_OP4_LO];
    assign op6         = instr_word[`CLMD_OP4_HI:`CLMD_OP6_LO];
    assign dest_file   = instr_word[`CLMD_DEST_BIT];
    assign faddr       = instr_word[`CLMD_FADDR_HI:0];
    assign imm         = instr_word[`CLMD_K_HI:0];

    // opcode matches; codes that match none of these or the loads below only advance the pc
    assign do_load_lit = go & (op4 == `CLMD_OP_LOAD_LIT);
    assign do_or_lit   = go & (op4 == `CLMD_OP_OR_LIT);
    assign do_xor_lit  = go & (op4 == `CLMD_OP_XOR_LIT);
    assign do_or_reg   = go & (op6 == `CLMD_OP_OR_REG);
    assign do_xor_reg  = go & (op6 == `CLMD_OP_XOR_REG);
    assign do_move_reg = go & (op6 == `CLMD_OP_MOVE_REG);

    // write-only loads that copy the accumulator
    assign do_config   = go & (instr_word == `CLMD_OP_CONFIG);
    assign do_dir      = go & (instr_word[`CLMD_OP4_HI:3] == `CLMD_OP_DIR_HI)
                       & (instr_word[2:0] >= `CLMD_DIR_SEL_A);

    // instruction classes
    assign is_lit      = do_load_lit | do_or_lit | do_xor_lit;
    assign is_reg      = do_or_reg | do_xor_reg | do_move_reg;

    ////////////////////////////////////////////////////////////////////////////
    // file read

    // effective file address after the indirect redirect
    wire [4:0] eff_addr;
    reg  [7:0] file_rd;

    // indirect slot redirects through the pointer's low five bits
    assign eff_addr = (faddr == `CLMD_FA_INDIRECT) ? pointer_reg_q[4:0] : faddr;

    // read mux; pointing the pointer at the indirect slot reads zero
    always @* begin
        case (eff_addr)
            `CLMD_FA_INDIRECT: file_rd = `CLMD_ZERO8;
            `CLMD_FA_TIMER:    file_rd = timer_count_q;
            `CLMD_FA_PCL:      file_rd = pc_q[7:0];
            `CLMD_FA_FLAGS:    file_rd = core_flags_q;
            `CLMD_FA_POINTER:  file_rd = pointer_reg_q;
            `CLMD_FA_PINS_A:   file_rd = {`CLMD_ZERO4, pins_group_a_in};
            `CLMD_FA_PINS_B:   file_rd = pins_group_b_in;
            `CLMD_FA_PINS_C:   file_rd = (SMALL_MEM != 0) ? file_mem[eff_addr]
                                                          : pins_group_c_in;
            default:           file_rd = file_mem[eff_addr];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // logic unit

    // one shared unit serves all six logic and move instructions
    reg  [1:0] lu_op;
    wire [7:0] lu_operand;
    wire [7:0] lu_result;
    wire       lu_zero;

    // operation choice from decode
    always @* begin
        if (do_or_lit | do_or_reg) begin
            lu_op = `CLMD_LU_OR;
        end else if (do_xor_lit | do_xor_reg) begin
            lu_op = `CLMD_LU_XOR;
        end else begin
            lu_op = `CLMD_LU_PASS;
        end
    end

    // literal forms take the immediate, register forms the file read
    assign lu_operand = is_lit ? imm : file_rd;

    clmd_logic_unit u_lu (
        .op      (lu_op),
        .acc     (acc_q),
        .operand (lu_operand),
        .result  (lu_result),
        .zero    (lu_zero)
    );

    ////////////////////////////////////////////////////////////////////////////
    // write decode

    // result routing and flag update strobes
    wire       wr_acc;
    wire       wr_file;
    wire       set_zero;
    wire       wr_file_data;

    // destination bit routes the result; moving back into f is a pure test
    assign wr_acc       = is_lit | (is_reg & ~dest_file);
    assign wr_file      = is_reg & dest_file;
    assign wr_file_data = wr_file & ~do_move_reg;
    assign set_zero     = is_reg | do_or_lit | do_xor_lit;

    ////////////////////////////////////////////////////////////////////////////
    // accumulator

    // taken on the accepting edge so the result shows one edge later;
    // direction and option loads read it without touching it
    always @(posedge clk_sys) begin
        if (rst) begin
            acc_q <= `CLMD_ZERO8;
        end else if (ce && wr_acc) begin
            acc_q <= lu_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flag register

    // expiry and power-down are read-only here; zero update wins over a write
    // warm reset clears the page bits and keeps the rest
    always @(posedge clk_sys) begin
        if (rst) begin
            if (por) begin
                core_flags_q <= `CLMD_RST_FLAGS;
            end else begin
                core_flags_q <= {3'h0, core_flags_q[`CLMD_FL_EXPIRY:0]};
            end
        end else if (ce) begin
            if (wr_file_data && eff_addr == `CLMD_FA_FLAGS) begin
                core_flags_q[`CLMD_FL_PAGE_HI:`CLMD_FL_PAGE_LO] <=
                    lu_result[`CLMD_FL_PAGE_HI:`CLMD_FL_PAGE_LO];
                core_flags_q[`CLMD_FL_LOW_HI-1:0] <= lu_result[`CLMD_FL_LOW_HI-1:0];
                core_flags_q[`CLMD_FL_ZERO] <= set_zero ? lu_zero : lu_result[`CLMD_FL_ZERO];
            end else if (set_zero) begin
                core_flags_q[`CLMD_FL_ZERO] <= lu_zero;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pointer register

    // warm reset keeps the low bits on small builds
    // large builds force only bit 7; the other bits start at zero here
    always @(posedge clk_sys) begin
        if (rst) begin
            if (SMALL_MEM != 0) begin
                pointer_reg_q[7:5] <= `CLMD_RST_PTR_TOP;
                if (por) begin
                    pointer_reg_q[4:0] <= 5'h00;
                end
            end else begin
                pointer_reg_q[7] <= `CLMD_RST_PTR_BIT7;
                if (por) begin
                    pointer_reg_q[6:0] <= 7'h00;
                end
            end
        end else if (ce && wr_file_data && eff_addr == `CLMD_FA_POINTER) begin
            pointer_reg_q <= lu_result;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // program counter

    wire [1:0] pc_page;

    // only the two lower page bits reach the counter; bit 8 is cleared
    assign pc_page = core_flags_q[`CLMD_FL_PAGE_HI-1:`CLMD_FL_PAGE_LO];

    // writing the low byte jumps within the page selected by flags 6:5;
    // upper bits have no file address of their own;
    // the pc advances on every accepted word but a low-byte write, unknown codes included
    always @(posedge clk_sys) begin
        if (rst) begin
            pc_q <= `CLMD_RST_PC;
        end else if (ce && wr_file_data && eff_addr == `CLMD_FA_PCL) begin
            pc_q <= {pc_page, 1'b0, lu_result};
        end else if (go) begin
            pc_q <= pc_q + `CLMD_ONE_PC;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timer count

    // free count on internal source; prescaler is outside this block
    // a write wins over the count so software sees the value it stored
    always @(posedge clk_sys) begin
        if (rst) begin
            if (por) begin
                timer_count_q <= `CLMD_ZERO8;
            end
        end else if (ce) begin
            if (wr_file_data && eff_addr == `CLMD_FA_TIMER) begin
                timer_count_q <= lu_result;
            end else if (!timer_prescale_config_q[`CLMD_CFG_CLK_SRC]) begin
                timer_count_q <= timer_count_q + `CLMD_ONE8;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration and directions

    // option and direction loads copy the accumulator; neither has a read path,
    // so software must keep its own copy of what it wrote
    always @(posedge clk_sys) begin
        if (rst) begin
            timer_prescale_config_q <= `CLMD_RST_CFG;
            direction_a_q           <= `CLMD_RST_DIR4;
            direction_b_q           <= `CLMD_RST_DIR8;
            direction_c_q           <= `CLMD_RST_DIR8;
        end else if (ce) begin
            if (do_config) begin
                timer_prescale_config_q <= acc_q[`CLMD_CFG_W-1:0];
            end
            if (do_dir) begin
                case (instr_word[2:0])
                    `CLMD_DIR_SEL_A: direction_a_q <= acc_q[`CLMD_PA_W-1:0];
                    `CLMD_DIR_SEL_B: direction_b_q <= acc_q;
                    `CLMD_DIR_SEL_C: begin
                        if (SMALL_MEM == 0) begin
                            direction_c_q <= acc_q;
                        end
                    end
                    default: direction_a_q <= direction_a_q;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pin latches

    // latches are cleared only by power-on reset; a warm reset keeps the last written value
    // reads come from the pins, so read-modify-write ops pick up pin levels
    always @(posedge clk_sys) begin
        if (rst) begin
            if (por) begin
                pins_group_a_q <= `CLMD_ZERO4;
                pins_group_b_q <= `CLMD_ZERO8;
                pins_group_c_q <= `CLMD_ZERO8;
            end
        end else if (ce && wr_file_data) begin
            case (eff_addr)
                `CLMD_FA_PINS_A: pins_group_a_q <= lu_result[`CLMD_PA_W-1:0];
                `CLMD_FA_PINS_B: pins_group_b_q <= lu_result;
                `CLMD_FA_PINS_C: begin
                    if (SMALL_MEM == 0) begin
                        pins_group_c_q <= lu_result;
                    end
                end
                default: pins_group_b_q <= pins_group_b_q;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // general purpose file

    // no reset on the array so it maps onto plain ram
    // the special slots below it are never written here
    always @(posedge clk_sys) begin
        if (ce && !rst && wr_file_data) begin
            if (eff_addr > `CLMD_FA_PINS_C ||
                (eff_addr == `CLMD_FA_PINS_C && SMALL_MEM != 0)) begin
                file_mem[eff_addr] <= lu_result;
            end
        end
    end

endmodule // clmd_core
`default_nettype wire

// ==== dv/clmd_core_monitor.sv ====
// checker for the core datapath, bound onto every clmd_core
// assumes it sees only the core's ports, one clock domain
`timescale 1ns/100ps
`default_nettype none
`include "clmd_map.vh"

module clmd_core_monitor #(
    parameter SMALL_MEM = 1
) (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        ce,
    input wire logic        por,
    input wire logic        instr_valid,
    input wire logic [11:0] instr_word,
    input wire logic [3:0]  pins_group_a_in,
    input wire logic [7:0]  acc_q,
    input wire logic [7:0]  core_flags_q,
    input wire logic [7:0]  pointer_reg_q,
    input wire logic [10:0] pc_q,
    input wire logic [5:0]  timer_prescale_config_q,
    input wire logic [7:0]  direction_b_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////
    // decode of the accepted word; pc writes come from any f=02h store
    wire       ex    = instr_valid && ce;
    wire [5:0] op6   = instr_word[11:6];
    wire       regop = ex && !instr_word[5] && (op6 == 6'h04 || op6 == 6'h06 || op6 == 6'h08);
    wire       pcw   = ex && instr_word[11:9] == 3'h0 && instr_word[5] && instr_word[4:0] == 5'h02;

    ////////////////////////////////////////////////////////////
    lit_or_a: assert property (ex && instr_word[11:8] == 4'hd |=>
        acc_q == ($past(acc_q) | $past(instr_word[7:0])) && core_flags_q[2] == (acc_q == 8'h00))
        else $error("literal or result wrong");
    lit_xor_a: assert property (ex && instr_word[11:8] == 4'hf |=>
        acc_q == ($past(acc_q) ^ $past(instr_word[7:0])) && core_flags_q[2] == (acc_q == 8'h00))
        else $error("literal xor result wrong");
    load_lit_a: assert property (ex && instr_word[11:8] == 4'hc |=>
        acc_q == $past(instr_word[7:0]) && $stable(core_flags_q)) else $error("literal load wrong");
    move_keep_a: assert property (ex && instr_word[11:5] == 7'h11 |=>
        $stable(acc_q) && $stable(pointer_reg_q)) else $error("move back changed data");
    reg_zero_a: assert property (regop |=> core_flags_q[2] == (acc_q == 8'h00))
        else $error("zero flag disagrees with result");
    pc_step_a: assert property (ex && !pcw |=> pc_q == $past(pc_q) + 11'h001)
        else $error("pc did not step by one");
    hold_off_a: assert property (!ce |=> $stable(acc_q) && $stable(pc_q))
        else $error("state moved with enable low");
    pins_a_read_a: assert property (ex && instr_word == 12'h205 |=>
        acc_q == {4'h0, $past(pins_group_a_in)}) else $error("pin group a read wrong");
    cold_vals_a: assert property (disable iff (1'b0) rst && por |=> core_flags_q == 8'h18
        && pc_q == 11'h7ff && timer_prescale_config_q == 6'h3f && direction_b_q == 8'hff)
        else $error("power-on values wrong");
    warm_keep_a: assert property (disable iff (1'b0) rst && !por |=>
        pointer_reg_q[7:5] == 3'h7 && pointer_reg_q[4:0] == $past(pointer_reg_q[4:0])
        && core_flags_q[4:0] == $past(core_flags_q[4:0])) else $error("warm reset lost state");

    // main scenarios reached
    c_xor: cover property (ex && instr_word[11:8] == 4'hf);
    c_ind: cover property (regop && instr_word[4:0] == 5'h00);
    c_warm: cover property (rst && !por);
endmodule // clmd_core_monitor

bind clmd_core clmd_core_monitor #(.SMALL_MEM(SMALL_MEM)) i_clmd_core_monitor (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .por(por), .instr_valid(instr_valid),
    .instr_word(instr_word), .pins_group_a_in(pins_group_a_in), .acc_q(acc_q),
    .core_flags_q(core_flags_q), .pointer_reg_q(pointer_reg_q), .pc_q(pc_q),
    .timer_prescale_config_q(timer_prescale_config_q), .direction_b_q(direction_b_q)
);
`default_nettype wire

// ==== dv/test_core_logic_move_datapath.sv ====
// self-checking bench for the core datapath, small-memory build
// assumes instructions are taken on enabled edges and read back through file moves
`timescale 1ns/100ps
`default_nettype none

module test_core_logic_move_datapath;
    logic        clk_sys = 1'b0;
    logic        rst, ce, por, instr_valid;
    logic [11:0] instr_word;
    logic [3:0]  pins_group_a_in;
    logic [7:0]  pins_group_b_in, pins_group_c_in;
    wire  [7:0]  acc_q, core_flags_q, pointer_reg_q, direction_b_q, direction_c_q;
    wire  [7:0]  timer_count_q, pins_group_b_q, pins_group_c_q;
    wire  [10:0] pc_q;
    wire  [5:0]  timer_prescale_config_q;
    wire  [3:0]  direction_a_q, pins_group_a_q;
    int          n_fail = 0;
    int          cmp_count = 0;

    clmd_core #(.SMALL_MEM(1)) i_clmd_core (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .por(por), .instr_valid(instr_valid),
        .instr_word(instr_word), .pins_group_a_in(pins_group_a_in), .pins_group_b_in(pins_group_b_in),
        .pins_group_c_in(pins_group_c_in), .acc_q(acc_q), .core_flags_q(core_flags_q),
        .pointer_reg_q(pointer_reg_q), .timer_count_q(timer_count_q), .pc_q(pc_q),
        .timer_prescale_config_q(timer_prescale_config_q), .pins_group_a_q(pins_group_a_q),
        .pins_group_b_q(pins_group_b_q), .pins_group_c_q(pins_group_c_q),
        .direction_a_q(direction_a_q), .direction_b_q(direction_b_q),
        .direction_c_q(direction_c_q)
    );

    // 200 MHz clock
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end

    ////////////////////////////////////////////////////////////
    task automatic chk_val(input logic [11:0] got, input logic [11:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected zero flag at %0t: got %b", $time, got);
        end
    endtask

    // one word per call, idle cycle after it so valid never toggles twice in a step
    task automatic exec(input logic [11:0] w);
        @(negedge clk_sys);
        instr_valid = 1'b1;
        instr_word = w;
        @(negedge clk_sys);
        instr_valid = 1'b0;
    endtask

    // force f to ones, xor it back to zero, then or the value in; an unwritten
    // location is unknown, and xoring an unknown with itself stays unknown
    task automatic put_f(input logic [4:0] f, input logic [7:0] v);
        exec(12'hcff);
        exec({7'h09, f});
        exec({7'h0d, f});
        exec({4'hc, v});
        exec({7'h09, f});
    endtask

    task automatic do_reset(input logic p);
        @(negedge clk_sys);
        rst = 1'b1;
        por = p;
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
    endtask

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // guard against a hang
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        $display("unexpected timeout at %0t", $time);
        stop_test();
    end

    ////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        por = 1'b1;
        ce = 1'b1;
        instr_valid = 1'b0;
        instr_word = 12'h000;
        pins_group_a_in = 4'ha;
        pins_group_b_in = 8'h3c;
        pins_group_c_in = 8'h00;
        repeat (20) @(negedge clk_sys);
        rst = 1'b0;
        chk_val(core_flags_q, 8'h18);
        chk_val(pc_q, 11'h7ff);
        chk_val(timer_prescale_config_q, 6'h3f);
        chk_val({direction_a_q, direction_b_q}, 12'hfff);
        chk_val(pointer_reg_q[7:5], 3'h7);
        $display("test power-on values done");
        exec(12'hc9a);
        exec(12'hd35);
        chk_val(acc_q, 8'hbf);
        exec(12'hc00);
        chk_bit(core_flags_q[2], 1'b0);
        exec(12'hd00);
        chk_bit(core_flags_q[2], 1'b1);
        exec(12'hcb5);
        chk_bit(core_flags_q[2], 1'b1);
        exec(12'hfaf);
        chk_val(acc_q, 8'h1a);
        exec(12'hf1a);
        chk_bit(core_flags_q[2], 1'b1);
        $display("test literal ops done");
        put_f(5'h10, 8'h13);
        exec(12'hc91);
        exec({7'h08, 5'h10});
        chk_val(acc_q, 8'h93);
        exec(12'hc40);
        exec({7'h09, 5'h10});
        exec({7'h10, 5'h10});
        chk_val(acc_q, 8'h53);
        put_f(5'h11, 8'haf);
        exec(12'hcb5);
        exec({7'h0d, 5'h11});
        chk_val(acc_q, 8'hb5);
        exec({7'h10, 5'h11});
        chk_val(acc_q, 8'h1a);
        exec({7'h0c, 5'h11});
        chk_bit(core_flags_q[2], 1'b1);
        put_f(5'h12, 8'h00);
        exec(12'hc01);
        exec({7'h11, 5'h12});
        chk_bit(core_flags_q[2], 1'b1);
        put_f(5'h12, 8'h80);
        exec({7'h11, 5'h12});
        chk_bit(core_flags_q[2], 1'b0);
        exec({7'h10, 5'h12});
        chk_val(acc_q, 8'h80);
        $display("test register ops done");
        put_f(5'h04, 8'h0a);
        put_f(5'h0a, 8'h5c);
        exec({7'h10, 5'h00});
        chk_val(acc_q, 8'h5c);
        exec(12'hc23);
        exec({7'h09, 5'h00});
        exec({7'h10, 5'h0a});
        chk_val(acc_q, 8'h7f);
        exec(12'h205);
        chk_val(acc_q, 8'h0a);
        exec(12'h206);
        chk_val(acc_q, 8'h3c);
        exec(12'hc41);
        exec({7'h09, 5'h06});
        exec({7'h09, 5'h05});
        chk_val(pins_group_b_q, 8'h7d);
        chk_val(pins_group_a_q, 4'hb);
        put_f(5'h07, 8'h66);
        exec(12'h207);
        chk_val(acc_q, 8'h66);
        chk_val(pins_group_c_q, 8'h00);
        $display("test file map done");
        exec(12'hc15);
        chk_val(timer_count_q, 8'h00);
        exec(12'h002);
        exec(12'h006);
        chk_val(timer_prescale_config_q, 6'h15);
        chk_val(direction_b_q, 8'h15);
        chk_val(timer_count_q, 8'h02);
        @(negedge clk_sys);
        ce = 1'b0;
        exec(12'hc00);
        chk_val(acc_q, 8'h15);
        chk_val(timer_count_q, 8'h03);
        ce = 1'b1;
        exec(12'h007);
        chk_val(direction_c_q, 8'hff);
        do_reset(1'b0);
        chk_val(pointer_reg_q, 8'hea);
        chk_val(core_flags_q[7:3], 5'h03);
        chk_val(direction_b_q, 8'hff);
        do_reset(1'b1);
        chk_val(pointer_reg_q[7:5], 3'h7);
        chk_val(timer_prescale_config_q, 6'h3f);
        $display("test resets done");
        stop_test();
    end
endmodule // test_core_logic_move_datapath
`default_nettype wire
